// ---- src/master_control_interrupt_regs.v ----
// Purpose: master reset, identity, configuration and interrupt status
// Assumes: synchronous 8-bit microprocessor port on i_clk
// Notes: open-drain pins given as out/enable pairs, enable low drives
`timescale 1ns/1ns
`include "master_ctrl_defs.vh"

// Notes on behaviour
// - unused config bits 7:6 store writes and read back; unused misc bits 7:4 read as zero
// - every writable configuration bit except active-link reads back its last written value
// - writable control bits reset to zero unless another default given
// - writes to read-only bits change nothing unless side effect defined
// - identity holds 4-bit revision low and 3-bit family code bits 6:4
// - any write to address zero loads all performance meters at once
// - software reset bit holds device in standby until written zero
// - hardware reset clears software reset; both reset otherwise alike
// - active-link bit picks link one (0) or two (1) for data, 8k
// - active-link reads link in use; writes ignored under auto select
// - auto-select bit, default one, lets device choose link from status
// - global enable lets enabled status pull interrupt low, else float
// - bit 3 or received code pulls reset pin low, else it floats
// - bit 4 samples receive lines on falling edge, else rising
// - bit 5 launches transmit lines on falling edge, else rising
// - status bits 0,1 follow link receiver pending, clear on its read
// - status bit 2 follows transmit count pending, clear on its read
// - status bits 3,4 follow channel buffer pending, clear on read
// - status bits 5,6 follow cell port pending, clear on port read
// - status bit 7 follows cpu cell buffer pending, clear on read
// - lock-change flag sets on lock status change, clears on misc read
// - lock status reads one when synthesiser outside 488 ppm window; no lock status bit is readable here, only the change flag in misc bit 0
// - misc bit 1 follows either link's code status pending
module master_control_interrupt_regs #(
  parameter LINES = 16,
  parameter [2:0] FAMILY_CODE = 3'h5, // arbitrary value
  parameter [3:0] REVISION = 4'hA // arbitrary value
) (
  input wire i_clk,
  input wire i_rst,
  // microprocessor port
  input wire i_cs_n,
  input wire i_wr_n,
  input wire i_rd_n,
  input wire [`ADDR_W-1:0] i_addr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  // sub-block pending levels (already enable-qualified)
  input wire [7:0] i_block_pending,
  input wire [7:0] i_block_status_read,
  input wire i_code_status_pending,
  input wire i_clocked_serial_pending,
  input wire i_cpu_extract_buf_pending,
  input wire i_synth_unlocked,
  input wire i_auto_link_choice,
  input wire i_code_reset_req,
  // serial link selection
  input wire i_serial_link_one_in,
  input wire i_serial_link_two_in,
  input wire i_timing_ref_8k_one,
  input wire i_timing_ref_8k_two,
  output reg o_active_link_data,
  output reg o_timing_ref_8k,
  // clocked serial buses
  input wire [LINES-1:0] i_serial_rx_clocks,
  input wire [LINES-1:0] i_serial_rx_lines,
  output wire [LINES-1:0] o_serial_rx_data,
  output wire [LINES-1:0] o_serial_rx_strobe,
  input wire [LINES-1:0] i_serial_tx_clocks,
  input wire [LINES-1:0] i_serial_tx_data,
  output reg [LINES-1:0] o_serial_tx_lines,
  // device-wide controls
  output wire o_device_reset,
  output reg o_load_meters,
  // open-drain pins: enable low drives output low
  output wire o_irq_out_n,
  output wire o_irq_out_n_oe_n,
  output wire o_reset_out_pin_n,
  output wire o_reset_out_pin_n_oe_n
);
  reg swrst_q;
  reg [7:0] cfg_q;
  reg active_q;
  reg [7:0] master_stat_q;
  reg lock_change_q;
  reg [2:0] lock_sync_q;
  reg lock_seen_q;
  reg [LINES-1:0] tx_s1_q;
  reg [LINES-1:0] tx_s2_q;
  reg [LINES-1:0] tx_s3_q;
  reg [LINES-1:0] tx_st_q;
  wire wr_strobe;
  wire rd_strobe;
  wire block_rst;
  wire [7:0] misc_stat;
  wire irq_any;
  wire lock_stable;
  wire [LINES-1:0] tx_edge;

  // address decode shared by read and write paths
  function hit;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  assign wr_strobe = ~i_cs_n & ~i_wr_n;
  assign rd_strobe = ~i_cs_n & ~i_rd_n;

  // soft reset holds
  // rest of device kept in standby while the bit stays one
  assign block_rst = i_rst | swrst_q;
  assign o_device_reset = block_rst;

  // software reset bit only; hardware reset or a written zero clears it
  // hardware clears soft
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      swrst_q <= 1'b0;
    end else if (wr_strobe && hit(i_addr, `ADDR_RESET_ID)) begin
      swrst_q <= i_wdata[`ID_SWRST];
    end
  end

  // meter load pulse
  // one pulse per write, independent of data written
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_load_meters <= 1'b0;
    end else begin
      o_load_meters <= wr_strobe && hit(i_addr, `ADDR_RESET_ID);
    end
  end

  // config defaults
  // configuration follows soft reset exactly as hardware reset
  always @(posedge i_clk or posedge block_rst) begin
    if (block_rst) begin
      cfg_q <= `CFG_RESET_VAL;
    end else if (wr_strobe && hit(i_addr, `ADDR_MASTER_CFG)) begin
      cfg_q <= i_wdata;
    end
  end

  always @(posedge i_clk or posedge block_rst) begin
    if (block_rst) begin
      active_q <= 1'b0;
    end else if (cfg_q[`CFG_AUTOSEL]) begin
      active_q <= i_auto_link_choice;
    end else if (wr_strobe && hit(i_addr, `ADDR_MASTER_CFG)) begin
      active_q <= i_wdata[`CFG_ACTIVE];
    end
  end

  always @(posedge i_clk or posedge block_rst) begin
    if (block_rst) begin
      o_active_link_data <= 1'b0;
      o_timing_ref_8k <= 1'b0;
    end else begin
      o_active_link_data <= active_q ? i_serial_link_two_in
                                     : i_serial_link_one_in;
      o_timing_ref_8k <= active_q ? i_timing_ref_8k_two
                                  : i_timing_ref_8k_one;
    end
  end

  // master status bits
  // sticky: a new pending in the read cycle wins over the clear
  always @(posedge i_clk or posedge block_rst) begin
    if (block_rst) begin
      master_stat_q <= 8'h00;
    end else begin
      master_stat_q <= i_block_pending |
                       (master_stat_q & ~i_block_status_read);
    end
  end

  // lock status synchroniser; stage one feeds only stage two
  always @(posedge i_clk or posedge block_rst) begin
    if (block_rst) begin
      lock_sync_q <= 3'h0;
    end else begin
      lock_sync_q <= {lock_sync_q[1:0], i_synth_unlocked};
    end
  end

  assign lock_stable = (lock_sync_q[1] == lock_sync_q[2]);

  // lock status source
  // change sets flag even in the cycle of the clearing read
  always @(posedge i_clk or posedge block_rst) begin
    if (block_rst) begin
      lock_seen_q <= 1'b0;
      lock_change_q <= 1'b0;
    end else begin
      if (lock_stable)
        lock_seen_q <= lock_sync_q[2];
      if (lock_stable && (lock_sync_q[2] != lock_seen_q))
        lock_change_q <= 1'b1;
      else if (rd_strobe && hit(i_addr, `ADDR_MISC_STAT))
        lock_change_q <= 1'b0;
    end
  end

  assign misc_stat = {4'h0, i_cpu_extract_buf_pending,
                      i_clocked_serial_pending, i_code_status_pending,
                      lock_change_q};

  always @* begin
    o_rdata = 8'h00;
    if (rd_strobe) begin
      case (i_addr)
        `ADDR_RESET_ID: o_rdata = {swrst_q, FAMILY_CODE, REVISION};
        `ADDR_MASTER_CFG: o_rdata = {cfg_q[7:1], active_q};
        `ADDR_MASTER_STAT: o_rdata = master_stat_q;
        `ADDR_MISC_STAT: o_rdata = misc_stat;
        default: o_rdata = 8'h00;
      endcase
    end
  end

  assign irq_any = (|master_stat_q) | (|misc_stat);
  assign o_irq_out_n = 1'b0;
  assign o_irq_out_n_oe_n = ~(cfg_q[`CFG_IRQ_EN] & irq_any);

  // reset pin drive
  // either register bit or inband code pulls the pin low
  assign o_reset_out_pin_n = 1'b0;
  assign o_reset_out_pin_n_oe_n = ~(cfg_q[`CFG_RST_OUT] | i_code_reset_req);

  sync_edge_sel #(
    .WIDTH(LINES)
  ) u_rx_capture (
    .i_clk(i_clk),
    .i_rst(block_rst),
    .i_invert(cfg_q[`CFG_RX_INV]),
    .i_line_clk(i_serial_rx_clocks),
    .i_data(i_serial_rx_lines),
    .o_data(o_serial_rx_data),
    .o_strobe(o_serial_rx_strobe)
  );

  // transmit clocks synchronised; stage one read by stage two only
  always @(posedge i_clk or posedge block_rst) begin
    if (block_rst) begin
      tx_s1_q <= {LINES{1'b0}};
      tx_s2_q <= {LINES{1'b0}};
      tx_s3_q <= {LINES{1'b0}};
      tx_st_q <= {LINES{1'b0}};
    end else begin
      tx_s1_q <= i_serial_tx_clocks;
      tx_s2_q <= tx_s1_q;
      tx_s3_q <= tx_s2_q;
      tx_st_q <= (tx_s2_q ~^ tx_s3_q) & tx_s3_q |
                 ~(tx_s2_q ~^ tx_s3_q) & tx_st_q;
    end
  end

  // transmit edge pick
  // launch on rising edge, or falling when inverted
  assign tx_edge = (tx_s2_q ~^ tx_s3_q) & (tx_s3_q ^ tx_st_q) &
                   (cfg_q[`CFG_TX_INV] ? ~tx_s3_q : tx_s3_q);

  // launch registers; lines hold between chosen edges
  always @(posedge i_clk or posedge block_rst) begin
    if (block_rst) begin
      o_serial_tx_lines <= {LINES{1'b0}};
    end else begin
      o_serial_tx_lines <= (tx_edge & i_serial_tx_data) |
                           (~tx_edge & o_serial_tx_lines);
    end
  end
endmodule // master_control_interrupt_regs

// ---- src/master_ctrl_defs.vh ----
// Purpose: offsets, field positions and reset values of the master group
// Assumes: 8-bit microprocessor port, normal-mode address space
// Notes: included by master_control_interrupt_regs only, not by sync_edge_sel
`ifndef MASTER_CTRL_DEFS_VH
`define MASTER_CTRL_DEFS_VH

`define ADDR_W 8
`define ADDR_RESET_ID 8'h00
`define ADDR_MASTER_CFG 8'h01
`define ADDR_MASTER_STAT 8'h02
`define ADDR_MISC_STAT 8'h03

`define CFG_ACTIVE 0
`define CFG_AUTOSEL 1
`define CFG_IRQ_EN 2
`define CFG_RST_OUT 3
`define CFG_RX_INV 4
`define CFG_TX_INV 5
`define CFG_RSVD_HI 7
`define CFG_RSVD_LO 6
`define CFG_RESET_VAL 8'h02
`define CFG_RESERVED_MASK 8'hC0

`define ID_SWRST 7
`define ID_TYPE_HI 6
`define ID_TYPE_LO 4
`define ID_REV_HI 3
`define ID_REV_LO 0

`define MISC_LOCK_CHG 0
`define MISC_CODE 1
`define MISC_CSD 2
`define MISC_XFIFO 3

`define SRC_LINK1 0
`define SRC_LINK2 1
`define SRC_TXCNT 2
`define SRC_RXCH 3
`define SRC_TXCH 4
`define SRC_CELLIN 5
`define SRC_CELLOUT 6
`define SRC_CPUBUF 7

`endif

// ---- src/sync_edge_sel.v ----
// Purpose: edge-selectable capture of serial lines, each on its own clock
// Assumes: line clocks arrive as pins, sampled into the system clock
// Notes: three-stage sync, change counts when stages two and three agree
`timescale 1ns/1ns
module sync_edge_sel #(
  parameter WIDTH = 16
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_invert,
  input wire [WIDTH-1:0] i_line_clk,
  input wire [WIDTH-1:0] i_data,
  output reg [WIDTH-1:0] o_data,
  output reg [WIDTH-1:0] o_strobe
);
  reg [WIDTH-1:0] clk_s1_q;
  reg [WIDTH-1:0] clk_s2_q;
  reg [WIDTH-1:0] clk_s3_q;
  reg [WIDTH-1:0] clk_st_q;
  reg [WIDTH-1:0] dat_s1_q;
  reg [WIDTH-1:0] dat_s2_q;
  reg [WIDTH-1:0] dat_s3_q;
  reg [WIDTH-1:0] dat_st_q;
  genvar g;

  // per-line synchronisers and edge pick
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_line
      always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          clk_s1_q[g] <= 1'b0;
          clk_s2_q[g] <= 1'b0;
          clk_s3_q[g] <= 1'b0;
          clk_st_q[g] <= 1'b0;
          dat_s1_q[g] <= 1'b0;
          dat_s2_q[g] <= 1'b0;
          dat_s3_q[g] <= 1'b0;
          dat_st_q[g] <= 1'b0;
          o_data[g] <= 1'b0;
          o_strobe[g] <= 1'b0;
        end else begin
          clk_s1_q[g] <= i_line_clk[g];
          clk_s2_q[g] <= clk_s1_q[g];
          clk_s3_q[g] <= clk_s2_q[g];
          dat_s1_q[g] <= i_data[g];
          dat_s2_q[g] <= dat_s1_q[g];
          dat_s3_q[g] <= dat_s2_q[g];
          // stable level only once two stages agree (glitch reject)
          if (clk_s2_q[g] == clk_s3_q[g])
            clk_st_q[g] <= clk_s3_q[g];
          if (dat_s2_q[g] == dat_s3_q[g])
            dat_st_q[g] <= dat_s3_q[g];
          // chosen edge: rising normally, falling when inverted
          o_strobe[g] <= (clk_s2_q[g] == clk_s3_q[g]) &&
                         (clk_s3_q[g] != clk_st_q[g]) &&
                         (clk_s3_q[g] == ~i_invert);
          if ((clk_s2_q[g] == clk_s3_q[g]) &&
              (clk_s3_q[g] != clk_st_q[g]) &&
              (clk_s3_q[g] == ~i_invert))
            o_data[g] <= dat_st_q[g];
        end
      end
    end
  endgenerate
endmodule // sync_edge_sel

// ---- tb/master_control_interrupt_regs_assertions.sv ----
// Purpose: port checks on the master register group
// Assumes: one clock, async active-high reset
// Notes: bound to the design from the bench top file
`timescale 1ns/1ns
module mcir_checker #(
  parameter [2:0] FAMILY_CODE = 3'h5, // arbitrary value
  parameter [3:0] REVISION = 4'hA // arbitrary value
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_cs_n,
  input wire i_wr_n,
  input wire i_rd_n,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire [7:0] i_block_pending,
  input wire [7:0] o_rdata,
  input wire o_device_reset,
  input wire o_load_meters,
  input wire o_irq_out_n,
  input wire o_irq_out_n_oe_n
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // decoded strobes shared by the properties
  wire wr = !i_cs_n && !i_wr_n;
  wire rd = !i_cs_n && !i_rd_n;
  wire wr0 = wr && i_addr == 8'h00;
  wire wr1 = wr && i_addr == 8'h01 && !o_device_reset;
  AST_LOAD: assert property (
    wr0 && !i_wdata[7] && !o_device_reset |=> o_load_meters)
    else $error("meter load pulse missing");
  AST_LOAD_CAUSE: assert property (
    o_load_meters |-> $past(wr0)) else $error("stray meter load");
  AST_ID: assert property (
    rd && i_addr == 8'h00 |-> o_rdata[6:0] == {FAMILY_CODE, REVISION})
    else $error("identity field wrong");
  AST_UNMAP: assert property (
    rd && i_addr > 8'h03 |-> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_CFG_RB: assert property (
    rd && i_addr == 8'h01 && !o_device_reset && $past(wr1)
    |-> (o_rdata & 8'hFE) == ($past(i_wdata) & 8'hFE))
    else $error("config readback wrong");
  AST_MSTAT: assert property (
    rd && i_addr == 8'h02 && !o_device_reset && !$past(o_device_reset)
    |-> (o_rdata & $past(i_block_pending)) == $past(i_block_pending))
    else $error("pending not latched");
  AST_SWRST: assert property (
    o_device_reset && !(wr0 && !i_wdata[7]) |=> o_device_reset)
    else $error("soft reset released itself");
  AST_IRQ_RST: assert property (
    o_device_reset && $past(o_device_reset) |-> o_irq_out_n_oe_n)
    else $error("interrupt driven in reset");
  AST_IRQ_VAL: assert property (
    !o_irq_out_n_oe_n |-> !o_irq_out_n) else $error("irq drives high");
  COV_LOAD: cover property (wr0 ##1 o_load_meters);
  COV_IRQ: cover property (!o_irq_out_n_oe_n);
  COV_SOFT: cover property (o_device_reset && !i_rst);
endmodule // mcir_checker

// ---- tb/test_master_control_interrupt_regs.sv ----
// Purpose: self-checking bench for the master register group
// Assumes: bench drives every input pin, 100 MHz clock
// Notes: expectations come from model variables, never the design
`timescale 1ns/1ns
module test_master_control_interrupt_regs;
  localparam [2:0] FAM = 3'h5; // arbitrary value
  localparam [3:0] REV = 4'hA; // arbitrary value
  reg i_clk = 1'b0, i_rst = 1'b1, i_cs_n = 1'b1, i_wr_n = 1'b1;
  reg i_rd_n = 1'b1, i_synth_unlocked = 1'b0, i_code_reset_req = 1'b0;
  reg [7:0] i_addr = 8'h00, i_wdata = 8'h00, i_block_pending = 8'h00;
  reg [7:0] i_block_status_read = 8'h00;
  reg i_code_status_pending = 1'b0, i_clocked_serial_pending = 1'b0;
  reg i_cpu_extract_buf_pending = 1'b0, i_auto_link_choice = 1'b0;
  reg i_serial_link_one_in = 1'b0, i_serial_link_two_in = 1'b0;
  reg i_timing_ref_8k_one = 1'b0, i_timing_ref_8k_two = 1'b0;
  reg [15:0] i_serial_rx_clocks = 16'h0000, i_serial_rx_lines = 16'h0000;
  reg [15:0] i_serial_tx_clocks = 16'h0000, i_serial_tx_data = 16'h0000;
  wire [7:0] o_rdata;
  wire [15:0] o_serial_rx_data, o_serial_tx_lines, o_serial_rx_strobe;
  wire o_active_link_data, o_timing_ref_8k, o_device_reset, o_load_meters;
  wire o_irq_out_n, o_irq_out_n_oe_n, o_reset_out_pin_n;
  wire o_reset_out_pin_n_oe_n;
  integer err_count = 0, n_compared = 0, cyc = 0, i, j;
  reg [7:0] r, d, m_cfg;
  reg [15:0] m_rx, m_tx;
  reg [3:0] z;
  master_control_interrupt_regs #(.LINES(16), .FAMILY_CODE(FAM),
    .REVISION(REV)) master_control_interrupt_regs_inst (.i_clk, .i_rst,
    .i_cs_n, .i_wr_n, .i_rd_n, .i_addr, .i_wdata, .o_rdata, .i_block_pending,
    .i_block_status_read, .i_code_status_pending, .i_clocked_serial_pending,
    .i_cpu_extract_buf_pending, .i_synth_unlocked, .i_auto_link_choice,
    .i_code_reset_req, .i_serial_link_one_in, .i_serial_link_two_in,
    .i_timing_ref_8k_one, .i_timing_ref_8k_two, .o_active_link_data,
    .o_timing_ref_8k, .i_serial_rx_clocks, .i_serial_rx_lines,
    .o_serial_rx_data, .o_serial_rx_strobe, .i_serial_tx_clocks,
    .i_serial_tx_data, .o_serial_tx_lines, .o_device_reset, .o_load_meters,
    .o_irq_out_n, .o_irq_out_n_oe_n, .o_reset_out_pin_n,
    .o_reset_out_pin_n_oe_n);
  // free-running clock
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  // hang guard, run needs well under this
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      err_count = err_count + 1;
      close_out;
    end
  end
  // release the port, then idle n cycles
  task nap(input integer n);
    i_cs_n = 1'b1;
    i_wr_n = 1'b1;
    i_rd_n = 1'b1;
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // one access; port left held so accesses run back to back
  task acc(input [7:0] a, input [7:0] v, input rdq, output [7:0] q);
    i_cs_n = 1'b0;
    i_wr_n = rdq;
    i_rd_n = !rdq;
    i_addr = a;
    i_wdata = v;
    #4 q = o_rdata;
    @(posedge i_clk);
    #1;
  endtask
  task chk(input [15:0] g, input [15:0] e);
    n_compared = n_compared + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // main sequence
  initial begin
    i = $urandom(49);
    m_cfg = 8'h02;
    m_rx = 16'h0000;
    m_tx = 16'h0000;
    repeat (5) @(posedge i_clk);
    #1 i_rst = 1'b0;
    acc(8'h01, 8'h00, 1'b1, r);
    chk(r, m_cfg);
    acc(8'h00, 8'h7F, 1'b0, r);
    acc(8'h02, 8'hFF, 1'b0, r);
    acc(8'h00, 8'h00, 1'b1, r);
    chk(r, {1'b0, FAM, REV});
    acc(8'h02, 8'h00, 1'b1, r);
    chk(r, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      d = 8'h04 + 8'($urandom % 252);
      acc(d, 8'($urandom), 1'b0, r);
      acc(d, 8'h00, 1'b1, r);
      chk(r, 8'h00);
    end
    for (i = 0; i < 6; i = i + 1) begin
      // reserved bits written zero; second write lands once auto is off
      // reserved bits zero
      m_cfg = 8'($urandom) & 8'h3D;
      acc(8'h01, m_cfg, 1'b0, r);
      acc(8'h01, m_cfg, 1'b0, r);
      acc(8'h01, 8'h00, 1'b1, r);
      chk(r, m_cfg);
    end
    // automatic choice overrides the written link bit
    acc(8'h01, 8'h03, 1'b0, r);
    for (i = 0; i < 2; i = i + 1) begin
      nap(1);
      i_auto_link_choice = ~i[0];
      nap(4);
      acc(8'h01, 8'h00, 1'b1, r);
      chk(r, {7'h01, ~i[0]});
    end
    for (i = 0; i < 4; i = i + 1) begin
      acc(8'h01, {7'h00, i[0]}, 1'b0, r);
      nap(1);
      z = 4'($urandom);
      {i_serial_link_one_in, i_serial_link_two_in, i_timing_ref_8k_one,
        i_timing_ref_8k_two} = z;
      nap(3);
      d = i[0] ? {6'h00, z[2], z[0]} : {6'h00, z[3], z[1]};
      chk({o_active_link_data, o_timing_ref_8k}, d);
    end
    // each pending source sticks until its own register is read
    acc(8'h01, 8'h04, 1'b0, r);
    for (i = 0; i < 8; i = i + 1) begin
      nap(1);
      i_block_pending = 8'h01 << i;
      nap(1);
      i_block_pending = 8'h00;
      nap(3);
      chk(o_irq_out_n_oe_n, 1'b0);
      acc(8'h02, 8'h00, 1'b1, r);
      chk(r, 8'h01 << i);
      nap(1);
      i_block_status_read = 8'h01 << i;
      nap(1);
      i_block_status_read = 8'h00;
      nap(2);
      acc(8'h02, 8'h00, 1'b1, r);
      chk(r, 8'h00);
      chk(o_irq_out_n_oe_n, 1'b1);
    end
    acc(8'h01, 8'h00, 1'b0, r);
    nap(1);
    i_block_pending = 8'hFF;
    nap(4);
    chk(o_irq_out_n_oe_n, 1'b1);
    i_block_pending = 8'h00;
    i_block_status_read = 8'hFF;
    nap(1);
    i_block_status_read = 8'h00;
    z = 4'($urandom);
    {i_code_status_pending, i_clocked_serial_pending,
      i_cpu_extract_buf_pending} = z[2:0];
    nap(2);
    acc(8'h03, 8'h00, 1'b1, r);
    chk(r, {4'h0, z[0], z[1], z[2], 1'b0});
    nap(1);
    {i_code_status_pending, i_clocked_serial_pending} = 2'b00;
    i_cpu_extract_buf_pending = 1'b0;
    // lock change flag in both directions, cleared by a read
    for (i = 0; i < 2; i = i + 1) begin
      i_synth_unlocked = ~i[0];
      nap(8);
      acc(8'h03, 8'h00, 1'b1, r);
      chk(r, 8'h01);
      acc(8'h03, 8'h00, 1'b1, r);
      chk(r, 8'h00);
    end
    acc(8'h01, 8'h08, 1'b0, r);
    nap(2);
    chk({o_reset_out_pin_n_oe_n, o_reset_out_pin_n}, 2'b00);
    acc(8'h01, 8'h00, 1'b0, r);
    nap(2);
    chk(o_reset_out_pin_n_oe_n, 1'b1);
    i_code_reset_req = 1'b1;
    nap(4);
    chk(o_reset_out_pin_n_oe_n, 1'b0);
    i_code_reset_req = 1'b0;
    // serial capture and launch, plain then inverted edges
    for (i = 0; i < 2; i = i + 1) begin
      acc(8'h01, i ? 8'h30 : 8'h00, 1'b0, r);
      for (j = 0; j < 2; j = j + 1) begin
        nap(2);
        i_serial_rx_lines = 16'($urandom);
        i_serial_tx_data = 16'($urandom);
        nap(2);
        i_serial_rx_clocks = j ? 16'h0000 : 16'hFFFF;
        i_serial_tx_clocks = j ? 16'h0000 : 16'hFFFF;
        nap(8);
        if (i == j) begin
          m_rx = i_serial_rx_lines;
          m_tx = i_serial_tx_data;
        end
        chk(o_serial_rx_data, m_rx);
        chk(o_serial_tx_lines, m_tx);
        chk(o_serial_rx_strobe, 16'h0000);
      end
    end
    // soft reset holds, clears config, needs a zero write to leave
    acc(8'h01, 8'h0C, 1'b0, r);
    acc(8'h00, 8'h80, 1'b0, r);
    nap(3);
    chk(o_device_reset, 1'b1);
    acc(8'h00, 8'h00, 1'b1, r);
    chk(r, {1'b1, FAM, REV});
    acc(8'h01, 8'h00, 1'b1, r);
    chk(r, 8'h02);
    acc(8'h00, 8'h00, 1'b0, r);
    nap(2);
    chk(o_device_reset, 1'b0);
    acc(8'h00, 8'h80, 1'b0, r);
    nap(1);
    i_rst = 1'b1;
    nap(2);
    i_rst = 1'b0;
    nap(1);
    chk(o_device_reset, 1'b0);
    close_out;
  end
endmodule // test_master_control_interrupt_regs

bind master_control_interrupt_regs mcir_checker #(
  .FAMILY_CODE(FAMILY_CODE), .REVISION(REVISION)) chk_inst (.i_clk, .i_rst,
  .i_cs_n, .i_wr_n, .i_rd_n, .i_addr, .i_wdata, .i_block_pending, .o_rdata,
  .o_device_reset, .o_load_meters, .o_irq_out_n, .o_irq_out_n_oe_n);
